// File: tb/sensor_rc_model.sv
// Purpose: rc sensor network on the drive and sense pins
// Assumes: resistor pins charge the sense node after DLY cycles
// Notes:   an undriven, unpulled node toggles to expose stale reads
`timescale 1ns/100ps
`default_nettype none

module sensor_rc_model #(
	parameter logic [5:0] PIN_CHAN = 6'h38,
	parameter logic [5:0] PIN_CAP  = 6'h00,
	parameter int         DLY      = 3
) (
	input  wire logic       sys_clk,
	input  wire logic [5:0] drive_pins_out,
	input  wire logic [5:0] drive_pins_oe,
	input  wire logic [1:0] pull_low,
	output var logic  [1:0] sense
);
	logic [7:0] dl [2];
	logic [5:0] res;
	initial begin
		sense = 2'h0;
		dl[0] = 8'h00;
		dl[1] = 8'h00;
	end

	always @(posedge sys_clk) begin
		for (int c = 0; c < 2; c++) begin
			// capacitor pins are left out of the node: they neither ground it nor charge it
			res = drive_pins_oe & ~PIN_CAP & (c ? PIN_CHAN : ~PIN_CHAN);
			dl[c] <= {dl[c][6:0], |(res & drive_pins_out)};
			if (|res)
				sense[c] <= dl[c][DLY-1];
			else if (pull_low[c])
				sense[c] <= 1'b0;
			else
				sense[c] <= ~sense[c];
		end
	end
endmodule // sensor_rc_model

`default_nettype wire

// File: tb/tb.sv
// Purpose: register level test of the converter
// Assumes: channel a has a capacitor on pin 1
// Notes:   edges seen on the sense node give the expected count
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

module tb;
	import rtof_pkg::*;
	localparam int LIMIT = 20000;
	logic        sys_clk = 0, rst = 1;
	logic [5:0]  awaddr = 0, araddr = 0, dout, doe;
	logic [31:0] wdata = 0, rdata, d;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, chb = 0, cnt_on = 0;
	logic [1:0]  bresp, rresp, r, sense, pull;
	logic [15:0] cnt;
	logic        prev0 = 0, prev1 = 0;
	int          error_cnt = 0, check_count = 0, cyc = 0, edges = 0;
	wire         sense_sel = chb ? sense[1] : sense[0];

	always #5 sys_clk = ~sys_clk;

	resistance_freq_converter #(.PIN_CAP(6'h02)) i_resistance_freq_converter (
		.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sense_input_a(sense[0]), .sense_input_b(sense[1]),
		.sense_a_pull_low(pull[0]), .sense_b_pull_low(pull[1]),
		.drive_pins_out(dout), .drive_pins_oe(doe));

	sensor_rc_model #(.PIN_CAP(6'h02)) i_sensor_rc_model (.sys_clk(sys_clk),
		.drive_pins_out(dout), .drive_pins_oe(doe), .pull_low(pull), .sense(sense));

	always @(posedge sense_sel) if (cnt_on) edges++;

	always @(posedge sys_clk) begin
		if (!rst) begin
			if (doe[1]) `CHK("cap level", 0, dout[1])
			if (doe[0] && !prev0) `CHK("cap first", 1, prev1)
		end
		prev0 <= doe[0];
		prev1 <= doe[1];
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
		logic b;
		b = 0;
		@(posedge sys_clk);
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
		while (!b) begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid && bready) begin
				b = 1;
				bready <= 0;
				`CHK("bresp", er, bresp)
			end
		end
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic g;
		g = 0;
		@(posedge sys_clk);
		araddr <= a; arvalid <= 1; rready <= 1;
		while (!g) begin
			@(posedge sys_clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid && rready) begin
				g = 1; v = rdata; rs = rresp;
				rready <= 0;
			end
		end
	endtask

	task automatic rchk(input string n, input logic [5:0] a, input logic [31:0] e);
		rd(a, d, r);
		`CHK(n, e, d)
		`CHK(n, RESP_OKAY, r)
	endtask

	// counts one channel; oscillation stopped by tri-stating before readout
	task automatic run_chan(input int ch, input logic [5:0] dir, input int pin);
		chb = ch[0];
		// channel b sets direction first; channel a enables first to exercise the cap lag
		wr(OFF_DIR, ch ? {26'h0, dir} : 32'h0);
		wr(OFF_SELECT, ch ? 32'h20 : 32'h10);
		`CHK("idle oe", 6'h00, doe)
		edges = 0;
		cnt_on = 1;
		wr(OFF_ENABLE, 1 << ch);
		rchk("zeroed", OFF_NIBBLE0, 0);
		wr(OFF_DIR, {26'h0, dir});
		repeat (400) @(posedge sys_clk);
		`CHK("drive", 1, doe[pin])
		`CHK("pull on", 0, pull[ch])
		// the cycle tracker reaches done after two sense edges in any gating mode
		rchk("status", OFF_ENABLE, (5 << ch) | (1 << DONE_POS));
		wr(OFF_DIR, 0);
		repeat (30) @(posedge sys_clk);
		cnt_on = 0;
		`CHK("stop oe", 6'h00, doe)
		`CHK("pull off", 1, pull[ch])
		for (int k = 0; k < 4; k++) begin
			rd(6'(OFF_NIBBLE0 + 4 * k), d, r);
			cnt[4*k+:4] = d[3:0];
		end
		`CHK("count", edges[15:0], cnt)
		`CHK("osc ran", 1, edges > 8)
		rchk("ovf", OFF_OVF, 0);
		wr(OFF_DISABLE, 1 << ch);
		rchk("off", OFF_ENABLE, 0);
	endtask

	initial begin
		int w;
		repeat (16) @(posedge sys_clk);
		rst <= 0;
		rchk("dir", OFF_DIR, DIR_RESET);
		rchk("select", OFF_SELECT, SEL_RESET);
		rchk("ovf", OFF_OVF, 0);
		`CHK("pull rst", 2'h3, pull)
		rd(6'h30, d, r);
		`CHK("unmapped", RESP_SLVERR, r)
		`CHK("unmapped", 0, d)
		wr(6'h30, 1, RESP_SLVERR);
		wr(OFF_OVF, 1);
		rchk("ro ovf", OFF_OVF, 0);
		run_chan(0, 6'h03, 0);
		run_chan(1, 6'h08, 3);
		// each countdown timer with a different gating method
		for (int i = 1; i < 4; i++) begin
			w = (i == 1) ? TIMER_ONE_W : (i == 2) ? TIMER_TWO_W : TIMER_THREE_W;
			wr(OFF_SELECT, 32'h10 | (i << 2) | i);
			rchk("select", OFF_SELECT, 32'h10 | (i << 2) | i);
			wr(OFF_ENABLE, 1);
			rchk("timer", 6'(OFF_TIMER_ONE + 4 * (i - 1)), (1 << w) - 1);
			wr(OFF_DISABLE, 1);
		end
		final_report();
	end
endmodule // tb

`default_nettype wire

// File: verilog/countdown_timer.sv
// Purpose: down counter preset to its maximum, stopping at zero
// Assumes: load and dec are one-cycle strobes
// Notes:   load wins over dec
`timescale 1ns/100ps
`default_nettype none

module countdown_timer #(
	parameter int WIDTH = 6
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic             dec,
	output logic      [WIDTH-1:0] value,
	output logic                  running
);
	import rtof_pkg::*;

	logic [WIDTH-1:0] value_r;

	always_ff @(posedge sys_clk) begin
		if (rst)
			value_r <= '0;
		else if (load)
			value_r <= '1;
		else if (dec && running)
			value_r <= value_r - WIDTH'(1);
	end

	assign value   = value_r;
	assign running = value_r != '0;

	a_timer_no_wrap: assert property (@(posedge sys_clk) disable iff (rst)
		!running && !load |=> !running) else $error("timer left zero without a load");

endmodule // countdown_timer

`default_nettype wire

// File: verilog/resistance_freq_converter.sv
// Purpose: resistance/capacitance to frequency converter with counter and bus slave
// Assumes: sense inputs asynchronous, synchronised here; AXI4-Lite on sys_clk
// Notes:   mask options are module parameters
`timescale 1ns/100ps
`default_nettype none

module resistance_freq_converter #(
	parameter int         REF_DIV  = rtof_pkg::REF_DIV_DEFAULT,
	parameter logic [5:0] PIN_CHAN = 6'h38,
	parameter logic [5:0] PIN_CAP  = 6'h00,
	parameter logic [1:0] LOW_IMP  = 2'h3,
	parameter bit         RESTART  = 1'b0,
	parameter int         T1_W     = rtof_pkg::TIMER_ONE_W,
	parameter int         T2_W     = rtof_pkg::TIMER_TWO_W,
	parameter int         T3_W     = rtof_pkg::TIMER_THREE_W
) (
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	input  wire logic [rtof_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [rtof_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  wire logic                         sense_input_a,
	input  wire logic                         sense_input_b,
	output logic                              sense_a_pull_low,
	output logic                              sense_b_pull_low,
	output logic [rtof_pkg::NUM_DRIVE-1:0]    drive_pins_out,
	output logic [rtof_pkg::NUM_DRIVE-1:0]    drive_pins_oe
);
	import rtof_pkg::*;

	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		return (a[1:0] == 2'h0) && (a <= OFF_TIMER_THREE);
	endfunction

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic                aw_held_r;
	logic                w_held_r;
	logic [ADDR_W-1:0]   awaddr_r;
	logic [31:0]         wdata_r;
	logic                wstrb0_r;
	logic                bvalid_r;
	logic [1:0]          bresp_r;
	logic                rvalid_r;
	logic [31:0]         rdata_r;
	logic [1:0]          rresp_r;
	logic [31:0]         rd_word;

	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready  = !w_held_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	wire do_wr  = aw_held_r & w_held_r & !bvalid_r;
	// all writable fields sit in byte 0, so only that lane matters
	wire wr_en  = do_wr & wstrb0_r & addr_known(awaddr_r);
	wire wr_set = wr_en & (awaddr_r == OFF_ENABLE);
	wire wr_clr = wr_en & (awaddr_r == OFF_DISABLE);
	wire wr_dir = wr_en & (awaddr_r == OFF_DIR);
	wire wr_sel = wr_en & (awaddr_r == OFF_SELECT);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (s_axi_awvalid && !aw_held_r) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (do_wr) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			w_held_r <= 1'b0;
			wdata_r  <= '0;
			wstrb0_r <= 1'b0;
		end else if (s_axi_wvalid && !w_held_r) begin
			w_held_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb0_r <= s_axi_wstrb[0];
		end else if (do_wr) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_r <= 1'b1;
			bresp_r  <= addr_known(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// command registers
	// ------------------------------------------------------------
	logic [NUM_SENSE-1:0] en_r;
	logic [NUM_DRIVE-1:0] dir_r;
	sel_type              sel_r;

	wire [NUM_SENSE-1:0] set_bits = wr_set ? wdata_r[NUM_SENSE-1:0] : '0;
	wire [NUM_SENSE-1:0] clr_bits = wr_clr ? wdata_r[NUM_SENSE-1:0] : '0;
	wire                 en_cmd   = |set_bits;

	always_ff @(posedge sys_clk) begin
		if (rst)
			en_r <= '0;
		else
			en_r <= (en_r | set_bits) & ~clr_bits;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dir_r <= DIR_RESET;
			sel_r <= sel_type'(SEL_RESET);
		end else begin
			if (wr_dir)
				dir_r <= wdata_r[NUM_DRIVE-1:0];
			if (wr_sel)
				sel_r <= sel_type'(wdata_r[5:0]);
		end
	end

	// ------------------------------------------------------------
	// sense inputs and oscillator drive
	// ------------------------------------------------------------
	logic [NUM_SENSE-1:0] sense_lvl;
	logic [NUM_SENSE-1:0] sense_rise;
	logic [NUM_SENSE-1:0] osc_run;
	logic [NUM_DRIVE-1:0] oe_nxt;
	logic [NUM_DRIVE-1:0] out_nxt;
	logic [NUM_DRIVE-1:0] drive_oe_r;
	logic [NUM_DRIVE-1:0] drive_out_r;
	logic [NUM_SENSE-1:0] pull_low_r;

	sense_sync #(.WIDTH(NUM_SENSE)) u_sense_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     ({sense_input_b, sense_input_a}),
		.level   (sense_lvl),
		.rise    (sense_rise)
	);

	for (genvar ch = 0; ch < NUM_SENSE; ch++) begin : g_chan
		wire [NUM_DRIVE-1:0] mask = (ch == 0) ? ~PIN_CHAN : PIN_CHAN;
		// a capacitor pin must have been grounded a cycle before the resistor pin drives
		wire cap_wait = |(dir_r & PIN_CAP & mask & ~drive_oe_r);
		assign osc_run[ch] = en_r[ch] & |(dir_r & ~PIN_CAP & mask) & !cap_wait;
	end

	for (genvar i = 0; i < NUM_DRIVE; i++) begin : g_pin
		wire run = osc_run[PIN_CHAN[i]];
		// capacitor pins only ever sink; resistor pins feed back the inverted sense level
		assign oe_nxt[i]  = dir_r[i] & (PIN_CAP[i] | run);
		assign out_nxt[i] = !PIN_CAP[i] & run & !sense_lvl[PIN_CHAN[i]];
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			drive_oe_r  <= '0;
			drive_out_r <= '0;
			pull_low_r  <= '0;
		end else begin
			drive_oe_r  <= oe_nxt;
			drive_out_r <= out_nxt;
			pull_low_r  <= LOW_IMP & ~osc_run;
		end
	end

	assign drive_pins_oe    = drive_oe_r;
	assign drive_pins_out   = drive_out_r;
	assign sense_a_pull_low = pull_low_r[0];
	assign sense_b_pull_low = pull_low_r[1];

	// ------------------------------------------------------------
	// gating and count events
	// ------------------------------------------------------------
	logic [15:0]          ref_cnt_r;
	cyc_state_type        cyc_r;
	cyc_state_type        cyc_nxt;
	logic                 gate_open;
	logic                 t2_run;

	wire [NUM_SENSE-1:0] src      = {sel_r.src_b, sel_r.src_a};
	wire                 ref_tick = ref_cnt_r == 16'(REF_DIV - 1);
	wire                 pin_ev   = |(src & en_r & sense_rise);
	wire                 pin_high = |(src & en_r & sense_lvl);
	wire                 pin_gate = (sel_r.gate == GATE_SOFTWARE) || (sel_r.gate == GATE_TIMER_TWO);
	// one-cycle and high-level gating count the internal reference, not the sense clock
	wire                 src_ev   = pin_gate ? pin_ev : ref_tick;
	wire                 cnt_ev   = gate_open & src_ev & (|en_r) & !en_cmd;

	always_ff @(posedge sys_clk) begin
		if (rst || ref_tick)
			ref_cnt_r <= '0;
		else
			ref_cnt_r <= ref_cnt_r + 16'h0001;
	end

	always_comb begin
		unique case (sel_r.gate)
			GATE_SOFTWARE:   gate_open = 1'b1;
			GATE_TIMER_TWO:  gate_open = t2_run && (sel_r.ctr != CTR_TIMER_TWO);
			GATE_ONE_CYCLE:  gate_open = cyc_r == CYC_COUNT;
			GATE_HIGH_LEVEL: gate_open = pin_high;
		endcase
	end

	always_comb begin
		cyc_nxt = cyc_r;
		if (en_cmd)
			cyc_nxt = CYC_ARMED;
		else if (en_r == '0)
			cyc_nxt = CYC_IDLE;
		else begin
			unique case (cyc_r)
				CYC_IDLE:  cyc_nxt = CYC_IDLE;
				CYC_ARMED: cyc_nxt = pin_ev ? CYC_COUNT : CYC_ARMED;
				CYC_COUNT: cyc_nxt = pin_ev ? CYC_DONE : CYC_COUNT;
				CYC_DONE:  cyc_nxt = CYC_DONE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			cyc_r <= CYC_IDLE;
		else
			cyc_r <= cyc_nxt;
	end

	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	logic [DED_W-1:0] ded_cnt_r;
	logic             ovf_r;
	logic             ded_halt_r;
	logic [T1_W-1:0]  t1_val;
	logic [T2_W-1:0]  t2_val;
	logic [T3_W-1:0]  t3_val;
	logic             t1_run;
	logic             t3_run;

	wire ded_ev  = cnt_ev & (sel_r.ctr == CTR_DEDICATED) & !ded_halt_r;
	wire ded_top = ded_cnt_r == '1;
	wire t2_gate = (sel_r.gate == GATE_TIMER_TWO) & (sel_r.ctr != CTR_TIMER_TWO);
	wire t2_dec  = (sel_r.ctr == CTR_TIMER_TWO) ? cnt_ev : (t2_gate & ref_tick & (|en_r));

	always_ff @(posedge sys_clk) begin
		if (rst || en_cmd) begin
			ded_cnt_r  <= '0;
			ovf_r      <= 1'b0;
			ded_halt_r <= 1'b0;
		end else if (ded_ev) begin
			ded_cnt_r <= ded_cnt_r + DED_W'(1);
			if (ded_top) begin
				ovf_r      <= RESTART ? !ovf_r : 1'b1;
				ded_halt_r <= !RESTART;
			end
		end
	end

	countdown_timer #(.WIDTH(T1_W)) u_timer_one (
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (en_cmd && (sel_r.ctr == CTR_TIMER_ONE)),
		.dec     (cnt_ev && (sel_r.ctr == CTR_TIMER_ONE)),
		.value   (t1_val),
		.running (t1_run)
	);

	countdown_timer #(.WIDTH(T2_W)) u_timer_two (
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (en_cmd && ((sel_r.ctr == CTR_TIMER_TWO) || t2_gate)),
		.dec     (t2_dec),
		.value   (t2_val),
		.running (t2_run)
	);

	countdown_timer #(.WIDTH(T3_W)) u_timer_three (
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (en_cmd && (sel_r.ctr == CTR_TIMER_THREE)),
		.dec     (cnt_ev && (sel_r.ctr == CTR_TIMER_THREE)),
		.value   (t3_val),
		.running (t3_run)
	);

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	wire [ADDR_W-1:0] ra     = s_axi_araddr;
	wire              ra_nib = (ra >= OFF_NIBBLE0) && (ra <= OFF_NIBBLE3);

	always_comb begin
		rd_word = '0;
		if (ra_nib)
			rd_word[3:0] = 4'(ded_cnt_r >> {ra[3:2], 2'h0});
		else begin
			unique case (ra)
				OFF_ENABLE: begin
					rd_word[EN_POS +: NUM_SENSE]  = en_r;
					rd_word[RUN_POS +: NUM_SENSE] = osc_run;
					rd_word[DONE_POS]             = cyc_r == CYC_DONE;
				end
				OFF_DIR:         rd_word[NUM_DRIVE-1:0] = dir_r;
				OFF_SELECT:      rd_word[5:0] = sel_r;
				OFF_OVF:         rd_word[0] = ovf_r;
				OFF_TIMER_ONE:   rd_word = 32'(t1_val);
				OFF_TIMER_TWO:   rd_word = 32'(t2_val);
				OFF_TIMER_THREE: rd_word = 32'(t3_val);
				default:         rd_word = '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_enable_zeroes: assert property (en_cmd |=> ded_cnt_r == '0 && !ovf_r)
		else $error("enable did not clear count and overflow");
	a_enable_clear_flag: assert property ($rose(ovf_r) |-> $past(!en_cmd))
		else $error("overflow flag set by an enable write");
	a_cap_ground_only: assert property ((drive_pins_out & PIN_CAP) == '0)
		else $error("capacitor pin driven high");
	a_cap_first: assert property ($rose(|(drive_pins_oe & ~PIN_CAP)) |->
		(drive_pins_oe & PIN_CAP) == ($past(drive_pins_oe) & PIN_CAP))
		else $error("resistor pin drove before capacitor ground");
	a_pull_low_idle: assert property (sense_a_pull_low |->
		(drive_pins_oe & ~PIN_CAP & ~PIN_CHAN) == '0)
		else $error("pull-low while oscillator drives");
	a_disable_stops_osc: assert property ($fell(en_r[0]) |=>
		(drive_pins_oe & ~PIN_CAP & ~PIN_CHAN) == '0)
		else $error("oscillator kept running after disable");
	a_needs_enable: assert property (en_r == '0 |=> (drive_pins_oe & ~PIN_CAP) == '0)
		else $error("resistor pin driven without enable");
	a_ovf_sets: assert property (ded_ev && ded_top |=>
		(RESTART ? ovf_r != $past(ovf_r) : ovf_r && ded_cnt_r == '0))
		else $error("overflow not flagged");
	a_stop_holds_zero: assert property (ded_halt_r && !en_cmd |=> ded_cnt_r == '0)
		else $error("stopped counter moved");
	a_count_steps: assert property (ded_ev && !ded_top |=>
		ded_cnt_r == $past(ded_cnt_r) + DED_W'(1))
		else $error("count did not advance by one");
	a_sw_disable_halts: assert property ($fell(|en_r) && sel_r.gate == GATE_SOFTWARE |->
		##1 $stable(ded_cnt_r)[*3])
		else $error("count moved after disable");
	a_timer_preset: assert property (en_cmd && sel_r.ctr == CTR_TIMER_ONE |=>
		t1_val == '1)
		else $error("timer not preset to maximum");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before ready");

endmodule // resistance_freq_converter

`default_nettype wire

// File: verilog/rtof_pkg.sv
// Purpose: shared constants and types of the resistance to frequency converter
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes:   offsets are byte addresses
`default_nettype none

package rtof_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int ADDR_W          = 6;
	localparam int NUM_SENSE       = 2;
	localparam int NUM_DRIVE       = 6;
	localparam int DED_W           = 16;
	localparam int TIMER_ONE_W     = 6;
	localparam int TIMER_TWO_W     = 12;
	localparam int TIMER_THREE_W   = 18;
	localparam int REF_DIV_DEFAULT = 8;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_ENABLE      = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_DISABLE     = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_DIR         = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_SELECT      = 6'h0C;
	localparam logic [ADDR_W-1:0] OFF_NIBBLE0     = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_NIBBLE3     = 6'h1C;
	localparam logic [ADDR_W-1:0] OFF_OVF         = 6'h20;
	localparam logic [ADDR_W-1:0] OFF_TIMER_ONE   = 6'h24;
	localparam logic [ADDR_W-1:0] OFF_TIMER_TWO   = 6'h28;
	localparam logic [ADDR_W-1:0] OFF_TIMER_THREE = 6'h2C;

	// status fields of the enable register on read
	localparam int EN_POS   = 0;
	localparam int RUN_POS  = 2;
	localparam int DONE_POS = 4;

	// reset values
	localparam logic [NUM_DRIVE-1:0] DIR_RESET = 6'h00;
	localparam logic [5:0]           SEL_RESET = 6'h10;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {CTR_DEDICATED, CTR_TIMER_ONE, CTR_TIMER_TWO,
		CTR_TIMER_THREE} ctr_type;
	typedef enum logic [1:0] {GATE_SOFTWARE, GATE_TIMER_TWO, GATE_ONE_CYCLE,
		GATE_HIGH_LEVEL} gate_type;
	typedef enum logic [1:0] {CYC_IDLE, CYC_ARMED, CYC_COUNT, CYC_DONE} cyc_state_type;

	typedef struct packed {
		logic     src_b;
		logic     src_a;
		gate_type gate;
		ctr_type  ctr;
	} sel_type;

endpackage

`default_nettype wire

// File: verilog/sense_sync.sv
// Purpose: two-flop synchroniser and rising edge detect for the sense inputs
// Assumes: inputs are free-running oscillator levels
// Notes:   the first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module sense_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);
	import rtof_pkg::*;

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] last_r;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_r <= '0;
			sync_r <= '0;
			last_r <= '0;
		end else begin
			meta_r <= din;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign rise  = sync_r & ~last_r;

endmodule // sense_sync

`default_nettype wire
